// ===== lps_ctrl.sv
// light and proximity sensing control with serial register port
`timescale 1ns/10ps
module lps_ctrl #(
    parameter int INT_BITS_MAX = 16
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [15:0] adc_sample_i,
    output logic sda_o,
    output logic sda_oe,
    output logic int_n_o,
    output logic ir_led_drive_output,
    output logic [1:0] ir_led_current_o,
    output lps_pkg::lps_phase_t phase_o
);
    import lps_pkg::*;

    lps_state_t st_ff;
    lps_state_t nxt_st;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic sda_bit;
    logic [2:0] mode_now;
    logic [1:0] sel;
    logic [4:0] res_n;
    logic [4:0] n_eff;
    logic [16:0] len;
    logic [15:0] mask;
    logic [4:0] pers;
    logic phase_end;
    logic out_win;

    assign sda_bit = st_ff.sda_s[1];
    assign scl_rise = st_ff.scl_s[1] & ~st_ff.scl_s[2];
    assign scl_fall = ~st_ff.scl_s[1] & st_ff.scl_s[2];
    assign bus_start = st_ff.scl_s[1] & st_ff.scl_s[2] & ~sda_bit & st_ff.sda_s[2];
    assign bus_stop = st_ff.scl_s[1] & st_ff.scl_s[2] & sda_bit & ~st_ff.sda_s[2];
    assign mode_now = st_ff.regs[REG_CMD1][MODE_MSB:MODE_LSB];
    assign sel = mode_now[1:0];

    always_comb begin
        case (st_ff.regs[REG_CMD2][RES_MSB:RES_LSB])
            2'h0: res_n = RES_BITS_0;
            2'h1: res_n = RES_BITS_1;
            2'h2: res_n = RES_BITS_2;
            default: res_n = RES_BITS_3;
        endcase
        case (st_ff.regs[REG_CMD1][PERS_MSB:PERS_LSB])
            2'h0: pers = PERS_0;
            2'h1: pers = PERS_1;
            2'h2: pers = PERS_2;
            default: pers = PERS_3;
        endcase
    end

    // integration length is 2^n cycles, capped for short simulations
    assign n_eff = (res_n > 5'(INT_BITS_MAX)) ? 5'(INT_BITS_MAX) : res_n; // RL11
    assign len = 17'd1 << n_eff; // RL11
    assign mask = 16'((17'd1 << res_n) - 17'd1);
    assign phase_end = (st_ff.phase != ph_idle) && (st_ff.icnt == len - 17'd1);

    always_comb begin
        logic mode_chg;
        logic [15:0] val;
        mode_chg = 1'b0;
        val = 16'h0000;
        out_win = 1'b0;
        nxt_st = st_ff;
        nxt_st.scl_s = {st_ff.scl_s[1:0], scl_i};
        nxt_st.sda_s = {st_ff.sda_s[1:0], sda_i};

        // serial register port
        if (bus_stop) begin
            nxt_st.i2c = i2c_idle;
            nxt_st.oe = 1'b0;
        end else if (bus_start) begin
            nxt_st.i2c = i2c_addr;
            nxt_st.bitcnt = 3'h0;
            nxt_st.first = 1'b1;
            nxt_st.oe = 1'b0;
        end else begin
            case (st_ff.i2c)
                i2c_idle: nxt_st.oe = 1'b0;
                i2c_addr: if (scl_rise) begin
                    nxt_st.sh = {st_ff.sh[6:0], sda_bit};
                    nxt_st.bitcnt = st_ff.bitcnt + 3'h1;
                    if (st_ff.bitcnt == 3'h7) begin
                        nxt_st.rw = sda_bit;
                        nxt_st.i2c = (st_ff.sh[6:0] == DEV_ADDR) ? i2c_ack : i2c_idle; // RL8
                    end
                end
                i2c_ack: if (scl_fall) begin
                    if (!st_ff.oe) begin
                        nxt_st.oe = 1'b1;
                    end else if (st_ff.rw) begin
                        nxt_st.sh = st_ff.regs[st_ff.ptr];
                        nxt_st.oe = ~st_ff.regs[st_ff.ptr][7];
                        nxt_st.bitcnt = 3'h0;
                        nxt_st.i2c = i2c_rd;
                    end else begin
                        nxt_st.oe = 1'b0;
                        nxt_st.bitcnt = 3'h0;
                        nxt_st.i2c = i2c_wr;
                    end
                end
                i2c_wr: if (scl_rise) begin
                    nxt_st.sh = {st_ff.sh[6:0], sda_bit};
                    nxt_st.bitcnt = st_ff.bitcnt + 3'h1;
                    if (st_ff.bitcnt == 3'h7) begin
                        nxt_st.i2c = i2c_ack;
                        if (st_ff.first) begin
                            nxt_st.first = 1'b0;
                            nxt_st.ptr = {st_ff.sh[1:0], sda_bit};
                        end else begin
                            nxt_st.ptr = st_ff.ptr + 3'h1;
                            if (st_ff.ptr == REG_CMD1) begin
                                nxt_st.regs[REG_CMD1] = {st_ff.sh[6:0], sda_bit};
                                // flag is only cleared by a write, never set
                                nxt_st.regs[REG_CMD1][FLAG_BIT] = st_ff.sh[FLAG_BIT - 1] &
                                    st_ff.regs[REG_CMD1][FLAG_BIT]; // RL12
                                mode_chg = st_ff.sh[6:4] != mode_now;
                                nxt_st.armed = 1'b1;
                            end else if (st_ff.ptr != REG_DATA_L && st_ff.ptr != REG_DATA_H) begin
                                nxt_st.regs[st_ff.ptr] = {st_ff.sh[6:0], sda_bit}; // RL9
                            end
                        end
                    end
                end
                i2c_rd: if (scl_fall) begin
                    nxt_st.bitcnt = st_ff.bitcnt + 3'h1;
                    if (st_ff.bitcnt == 3'h7) begin
                        nxt_st.oe = 1'b0;
                        nxt_st.i2c = i2c_rack;
                    end else begin
                        nxt_st.sh = {st_ff.sh[6:0], 1'b0};
                        nxt_st.oe = ~st_ff.sh[6];
                    end
                end
                i2c_rack: if (scl_rise) begin
                    if (sda_bit) begin
                        nxt_st.i2c = i2c_idle;
                    end else begin
                        nxt_st.ptr = st_ff.ptr + 3'h1;
                    end
                end else if (scl_fall) begin
                    nxt_st.sh = st_ff.regs[st_ff.ptr];
                    nxt_st.oe = ~st_ff.regs[st_ff.ptr][7];
                    nxt_st.bitcnt = 3'h0;
                    nxt_st.i2c = i2c_rd;
                end
                default: nxt_st.i2c = i2c_idle;
            endcase
        end

        // detection cycle sequencer
        if (st_ff.phase == ph_idle) begin
            nxt_st.icnt = 17'h0;
            if (sel != SEL_OFF && st_ff.armed) begin
                nxt_st.phase = ph_ambient_light; // RL6
            end
        end else if (sel == SEL_OFF) begin
            nxt_st.phase = ph_idle;
        end else begin
            nxt_st.icnt = st_ff.icnt + 17'h1;
            if (phase_end) begin
                nxt_st.icnt = 17'h0;
                if (st_ff.phase == lps_phase_t'(sel)) begin
                    nxt_st.cap = adc_sample_i & mask;
                end
                case (st_ff.phase)
                    ph_ambient_light: nxt_st.phase = ph_infrared; // RL6
                    ph_infrared: nxt_st.phase = ph_proximity; // RL6
                    default: begin
                        nxt_st.phase = ph_idle;
                        nxt_st.regs[REG_DATA_L] = nxt_st.cap[7:0]; // RL10
                        nxt_st.regs[REG_DATA_H] = nxt_st.cap[15:8]; // RL10
                        if (!mode_now[CONT_BIT]) begin
                            nxt_st.armed = 1'b0;
                        end
                        if (sel == SEL_LIGHT || sel == SEL_PROX) begin
                            val = nxt_st.cap; // RL1
                            out_win = val < {st_ff.regs[REG_LOWER_H], st_ff.regs[REG_LOWER_L]} ||
                                val > {st_ff.regs[REG_UPPER_H], st_ff.regs[REG_UPPER_L]};
                            if (out_win) begin
                                if (st_ff.pcnt != 5'h1f) begin
                                    nxt_st.pcnt = st_ff.pcnt + 5'h1;
                                end
                                if (st_ff.pcnt + 5'h1 >= pers) begin
                                    nxt_st.regs[REG_CMD1][FLAG_BIT] = 1'b1; // RL12
                                end
                            end else begin
                                nxt_st.pcnt = 5'h0;
                            end
                        end
                    end
                endcase
            end
        end
        if (mode_chg) begin
            nxt_st.pcnt = 5'h0; // RL3
        end

        // led drive, modulated only while the proximity phase runs; the count starts
        // one clock into the phase so that the first on half is as long as the rest
        if (st_ff.phase == ph_proximity) begin
            if (st_ff.mcnt == MOD_HALF_CYC - 6'h1) begin
                nxt_st.mcnt = 6'h0;
                nxt_st.mclk = ~st_ff.mclk; // RL4
            end else begin
                nxt_st.mcnt = st_ff.mcnt + 6'h1;
            end
        end else begin
            nxt_st.mcnt = 6'h0;
            nxt_st.mclk = 1'b1;
        end
        nxt_st.led = (nxt_st.phase == ph_proximity) &&
            (!st_ff.regs[REG_CMD2][MOD_BIT] || nxt_st.mclk); // RL7
        nxt_st.cur = st_ff.regs[REG_CMD2][CUR_MSB:CUR_LSB]; // RL5 RL13
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '0;
            st_ff.scl_s <= 3'h7;
            st_ff.sda_s <= 3'h7;
            st_ff.i2c <= i2c_idle;
            st_ff.phase <= ph_idle;
            st_ff.regs[REG_UPPER_L] <= UPPER_RST;
            st_ff.regs[REG_UPPER_H] <= UPPER_RST;
            st_ff.regs[REG_LOWER_L] <= LOWER_RST;
            st_ff.regs[REG_LOWER_H] <= LOWER_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe = st_ff.oe;
    assign int_n_o = ~st_ff.regs[REG_CMD1][FLAG_BIT];
    assign ir_led_drive_output = st_ff.led;
    assign ir_led_current_o = st_ff.cur;
    assign phase_o = st_ff.phase;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    led_prox_only_a: assert property (st_ff.led |-> st_ff.phase == ph_proximity) // RL7
        else $error("led on outside proximity phase");
    led_dc_on_a: assert property (st_ff.phase == ph_proximity &&
        !$past(st_ff.regs[REG_CMD2][MOD_BIT]) |-> st_ff.led) // RL4
        else $error("dc led drive not on in proximity phase");
    mod_half_a: assert property ($fell(st_ff.led) && st_ff.phase == ph_proximity &&
        $past(st_ff.phase) == ph_proximity |-> $past(st_ff.mcnt) == MOD_HALF_CYC - 6'h1) // RL4
        else $error("led modulation half period wrong");
    phase_order_a: assert property ($changed(st_ff.phase) && st_ff.phase == ph_infrared
        |-> $past(st_ff.phase) == ph_ambient_light) // RL6
        else $error("infrared phase not after ambient phase");
    prox_order_a: assert property ($changed(st_ff.phase) && st_ff.phase == ph_proximity
        |-> $past(st_ff.phase) == ph_infrared) // RL6
        else $error("proximity phase not after infrared phase");
    mode_pcnt_a: assert property ($changed(st_ff.regs[REG_CMD1][MODE_MSB:MODE_LSB])
        |-> st_ff.pcnt == 5'h0) // RL3
        else $error("persistence count kept over mode change");
    addr_miss_a: assert property (st_ff.i2c == i2c_addr && scl_rise && !bus_start &&
        !bus_stop && st_ff.bitcnt == 3'h7 && st_ff.sh[6:0] != DEV_ADDR
        |=> st_ff.i2c == i2c_idle && !st_ff.oe) // RL8
        else $error("foreign address acknowledged");
    data_update_a: assert property ($changed(st_ff.regs[REG_DATA_L])
        |-> $past(st_ff.phase) == ph_proximity && st_ff.phase == ph_idle) // RL10
        else $error("result changed outside cycle end");
    flag_cause_a: assert property ($rose(st_ff.regs[REG_CMD1][FLAG_BIT])
        |-> $past(sel) == SEL_LIGHT || $past(sel) == SEL_PROX) // RL1 RL12
        else $error("flag raised in a mode without thresholds");
    int_pin_a: assert property ($rose(st_ff.regs[REG_CMD1][FLAG_BIT]) |=> !int_n_o [*2]) // RL12
        else $error("interrupt pin not held");

    cyc_full_c: cover property (st_ff.phase == ph_proximity ##1 st_ff.phase == ph_idle);
    flag_set_c: cover property ($rose(st_ff.regs[REG_CMD1][FLAG_BIT]));
    read_c: cover property (st_ff.i2c == i2c_rack ##1 st_ff.i2c == i2c_rd);
    led_mod_c: cover property ($fell(st_ff.led) && st_ff.phase == ph_proximity);
endmodule : lps_ctrl

// ===== lps_pkg.sv
// package of constants and types for the light and proximity sensing control
//
// Function
// RL1 - thresholds compare light or proximity per mode
// RL2 - host reloads thresholds after each mode change
// RL3 - mode change clears persistence counter
// RL4 - proximity LED drive DC or 360kHz
// RL5 - two-bit field selects LED current
// RL6 - cycle runs light, infrared, proximity phases
// RL7 - LED enabled only in proximity phase
// RL8 - respond only at address 1000100
// RL9 - threshold registers and reset values
// RL10 - result bytes refresh each conversion cycle
// RL11 - resolution field sets 2^n cycle integration
// RL12 - persistent excursion raises held interrupt flag
// RL13 - current codes map increasing 12.5 to 100mA
package lps_pkg;
    localparam logic [6:0] DEV_ADDR = 7'h44;
    localparam logic [2:0] REG_CMD1 = 3'h0;
    localparam logic [2:0] REG_CMD2 = 3'h1;
    localparam logic [2:0] REG_DATA_L = 3'h2;
    localparam logic [2:0] REG_DATA_H = 3'h3;
    localparam logic [2:0] REG_LOWER_L = 3'h4;
    localparam logic [2:0] REG_LOWER_H = 3'h5;
    localparam logic [2:0] REG_UPPER_L = 3'h6;
    localparam logic [2:0] REG_UPPER_H = 3'h7;
    localparam logic [7:0] LOWER_RST = 8'h00;
    localparam logic [7:0] UPPER_RST = 8'hff;
    // command register 1 fields
    localparam int MODE_MSB = 7;
    localparam int MODE_LSB = 5;
    localparam int CONT_BIT = 2;
    localparam int FLAG_BIT = 2;
    localparam int PERS_MSB = 1;
    localparam int PERS_LSB = 0;
    // command register 2 fields
    localparam int MOD_BIT = 6;
    localparam int CUR_MSB = 5;
    localparam int CUR_LSB = 4;
    localparam int RES_MSB = 3;
    localparam int RES_LSB = 2;
    // data select within the mode field
    localparam logic [1:0] SEL_OFF = 2'h0;
    localparam logic [1:0] SEL_LIGHT = 2'h1;
    localparam logic [1:0] SEL_INFRARED = 2'h2;
    localparam logic [1:0] SEL_PROX = 2'h3;
    // resolution codes, bits of integration
    localparam logic [4:0] RES_BITS_0 = 5'h10;
    localparam logic [4:0] RES_BITS_1 = 5'h0c;
    localparam logic [4:0] RES_BITS_2 = 5'h08;
    localparam logic [4:0] RES_BITS_3 = 5'h04;
    // persistence counts per code
    localparam logic [4:0] PERS_0 = 5'h01;
    localparam logic [4:0] PERS_1 = 5'h04;
    localparam logic [4:0] PERS_2 = 5'h08;
    localparam logic [4:0] PERS_3 = 5'h10;
    // led modulation timing
    localparam int CLK_HZ = 40000000;
    localparam int LED_MOD_HZ = 360000;
    localparam logic [5:0] MOD_HALF_CYC = 6'(CLK_HZ / (2 * LED_MOD_HZ));

    typedef enum logic [2:0] {
        i2c_idle, i2c_addr, i2c_ack, i2c_wr, i2c_rd, i2c_rack
    } lps_i2c_t;

    typedef enum logic [1:0] {
        ph_idle, ph_ambient_light, ph_infrared, ph_proximity
    } lps_phase_t;

    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        lps_i2c_t i2c;
        logic [2:0] bitcnt;
        logic [7:0] sh;
        logic [2:0] ptr;
        logic rw;
        logic first;
        logic oe;
        logic [7:0][7:0] regs;
        lps_phase_t phase;
        logic armed;
        logic [16:0] icnt;
        logic [15:0] cap;
        logic [4:0] pcnt;
        logic [5:0] mcnt;
        logic mclk;
        logic led;
        logic [1:0] cur;
    } lps_state_t;
endpackage : lps_pkg

// ===== lps_host.sv
// serial bus host model for the sensing control register port
`timescale 1ns/10ps
module lps_host (
    input wire logic clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_low
);
    import lps_pkg::*;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic hw(input int n);
        repeat (n) @(negedge clk);
    endtask : hw

    task automatic start_c;
        sda_low = 1'b0;
        hw(2);
        scl = 1'b1;
        hw(4);
        sda_low = 1'b1;
        hw(4);
        scl = 1'b0;
    endtask : start_c

    task automatic stop_c;
        hw(2);
        sda_low = 1'b1;
        hw(2);
        scl = 1'b1;
        hw(4);
        sda_low = 1'b0;
        hw(4);
    endtask : stop_c

    // eight data bits then the acknowledge slot; data changes mid low phase
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            hw(2);
            sda_low = ~d[i];
            hw(2);
            scl = 1'b1;
            hw(4);
            q[i] = sda_line;
            scl = 1'b0;
        end
    endtask : xfer

    task automatic access(input logic [2:0] ptr, input logic rd, input logic [7:0] wd,
        output logic [7:0] rdat, output logic ok);
        logic [8:0] q0;
        logic [8:0] q1;
        logic [8:0] q2 = 9'h000;
        logic [8:0] q3;
        start_c();
        xfer({DEV_ADDR, 2'b01}, q0);
        xfer({5'h00, ptr, 1'b1}, q1);
        if (rd) begin
            start_c();
            xfer({DEV_ADDR, 2'b11}, q2);
        end
        xfer(rd ? 9'h1ff : {wd, 1'b1}, q3);
        stop_c();
        rdat = q3[8:1];
        ok = ~q0[0] & ~q1[0] & ~q2[0] & (rd | ~q3[0]);
    endtask : access

    task automatic probe(input logic [6:0] addr, output logic ack);
        logic [8:0] q;
        start_c();
        xfer({addr, 2'b01}, q);
        stop_c();
        ack = ~q[0];
    endtask : probe
endmodule : lps_host

// ===== lps_ctrl_tb.sv
// testbench for the light and proximity sensing control
`timescale 1ns/10ps
module lps_ctrl_tb;
    import lps_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [15:0] adc_sample_i = 16'h0000;
    logic scl;
    logic sda_low;
    logic sda_o;
    logic sda_oe;
    logic int_n_o;
    logic ir_led_drive_output;
    logic [1:0] ir_led_current_o;
    lps_phase_t phase_o;
    lps_phase_t last_ph;
    wire sda_line;
    int fail_count = 0;
    int checked = 0;
    int led_on;
    int dur;
    int base;
    int done_cnt = 0;
    logic ok;
    logic [6:0] bad [3] = '{7'h45, 7'h04, 7'h4c};

    always #12.5 core_clk = ~core_clk;
    // data line has a pull-up; either party may pull it low
    assign sda_line = ~(sda_low | (sda_oe & ~sda_o));

    lps_ctrl #(.INT_BITS_MAX(8)) i_lps_ctrl (.core_clk(core_clk), .arst_n(arst_n),
        .scl_i(scl), .sda_i(sda_line), .adc_sample_i(adc_sample_i), .sda_o(sda_o),
        .sda_oe(sda_oe), .int_n_o(int_n_o), .ir_led_drive_output(ir_led_drive_output),
        .ir_led_current_o(ir_led_current_o), .phase_o(phase_o));
    lps_host i_lps_host (.clk(core_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

    always @(negedge core_clk) adc_sample_i <= {8'ha5, 4'h3, 2'b01, phase_o};

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    always @(negedge core_clk) begin
        if (last_ph === ph_proximity && phase_o === ph_idle) done_cnt++;
        if (arst_n && phase_o !== ph_proximity && ir_led_drive_output !== 1'b0) begin
            chk({15'h0, ir_led_drive_output}, 16'h0);
        end
        last_ph = phase_o;
    end

    task automatic wr(input logic [2:0] ptr, input logic [7:0] d);
        logic [7:0] q;
        logic a;
        i_lps_host.access(ptr, 1'b0, d, q, a);
        chk({15'h0, a}, 16'h1);
    endtask : wr

    task automatic rd(input logic [2:0] ptr, input logic [7:0] exp);
        logic [7:0] q;
        logic a;
        i_lps_host.access(ptr, 1'b1, 8'h00, q, a);
        chk({7'h0, a, q}, {8'h1, exp});
    endtask : rd

    task automatic thr(input logic [15:0] up);
        wr(REG_LOWER_L, 8'h00);
        wr(REG_LOWER_H, 8'h00);
        wr(REG_UPPER_L, up[7:0]);
        wr(REG_UPPER_H, up[15:8]);
    endtask : thr

    function automatic int mod_on(input int len);
        int s = 0;
        for (int i = 0; i < len; i++) s += int'((i / int'(MOD_HALF_CYC)) % 2 == 0);
        return s;
    endfunction : mod_on

    // start a one-shot cycle and time each phase and the led
    task automatic cyc(input logic [7:0] cmd, input int len, input int led);
        int n;
        fork
            wr(REG_CMD1, cmd);
            begin
                n = 0;
                while (phase_o !== ph_ambient_light && n < 3000) begin
                    @(negedge core_clk);
                    n++;
                end
                for (int p = 1; p < 4; p++) begin
                    dur = 0;
                    led_on = 0;
                    chk(16'(phase_o), 16'(p));
                    while (phase_o === lps_phase_t'(p) && dur < 9000) begin
                        led_on += int'(ir_led_drive_output === 1'b1);
                        dur++;
                        @(negedge core_clk);
                    end
                    chk(16'(dur), 16'(len));
                end
                chk(16'(led_on), 16'(led));
                chk(16'(phase_o), 16'(ph_idle));
            end
        join
    endtask : cyc

    task automatic wait_done(input int k);
        int n = 0;
        while (done_cnt < k && n < 20000) begin
            @(negedge core_clk);
            n++;
        end
        repeat (4) @(negedge core_clk);
    endtask : wait_done

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (40000) @(posedge core_clk);
        fail_count++;
        stop_test();
    end

    initial begin
        repeat (3) @(negedge core_clk);
        arst_n = 1'b1;
        repeat (8) @(negedge core_clk);
        for (int a = 4; a < 8; a++) rd(3'(a), (a < 6) ? 8'h00 : 8'hff);
        rd(REG_DATA_L, 8'h00);
        wr(REG_DATA_L, 8'h5a);
        rd(REG_DATA_L, 8'h00);
        foreach (bad[i]) begin
            i_lps_host.probe(bad[i], ok);
            chk({15'h0, ok}, 16'h0);
        end
        for (int c = 0; c < 4; c++) begin
            wr(REG_CMD2, {2'b00, 2'(c), 4'hc});
            chk({14'h0, ir_led_current_o}, 16'(c));
        end
        for (int m = 1; m < 4; m++) begin
            wr(REG_CMD1, 8'h00);
            thr(16'h0005);
            cyc({1'b0, 2'(m), 5'h00}, 16, 16);
            rd(REG_DATA_L, {6'h01, 2'(m)});
            rd(REG_DATA_H, 8'h00);
            chk({15'h0, int_n_o}, (m == 3) ? 16'h0 : 16'h1);
        end
        repeat (200) @(negedge core_clk);
        rd(REG_CMD1, 8'h64);
        chk({15'h0, int_n_o}, 16'h0);
        wr(REG_CMD1, 8'h00);
        chk({15'h0, int_n_o}, 16'h1);
        for (int r = 0; r < 4; r++) begin
            wr(REG_CMD2, {4'h0, 2'(r), 2'b00});
            cyc(8'h60, (r == 3) ? 16 : 256, (r == 3) ? 16 : 256);
            rd(REG_DATA_H, (r == 0) ? 8'ha5 : (r == 1) ? 8'h05 : 8'h00);
        end
        wr(REG_CMD2, 8'h48);
        cyc(8'h60, 256, mod_on(256));
        wr(REG_CMD1, 8'h00);
        thr(16'h0003);
        wr(REG_CMD1, 8'ha1);
        wait_done(done_cnt + 2);
        chk({15'h0, int_n_o}, 16'h1);
        wr(REG_CMD1, 8'he1);
        base = done_cnt;
        wait_done(base + 3);
        chk({15'h0, int_n_o}, 16'h1);
        wait_done(base + 4);
        chk({15'h0, int_n_o}, 16'h0);
        wr(REG_CMD1, 8'h00);
        chk({15'h0, int_n_o}, 16'h1);
        stop_test();
    end
endmodule : lps_ctrl_tb
